// ---- rtc_calibration_and_flags.sv ----
module rtc_calibration_and_flags (
  input  wire logic        sys_clk,        // system clock, 100 MHz
  input  wire logic        rst,            // synchronous reset, active high
  input  wire logic        oscIn,          // 32,768 Hz crystal oscillator, async
  input  wire logic        powerUp,        // main supply came up, async level
  input  wire logic        batteryAttach,  // battery attached / first power, async
  input  wire logic        mainSupplyOk,   // nominal main supply present, async
  input  wire logic        batteryLowIn,   // battery comparator below ~2.5 V, async
  input  wire logic        tamperFlagIn,   // tamper flag from tamper logic, same clock
  input  wire logic        regWrite,       // register write strobe
  input  wire logic        regRead,        // register read strobe
  input  wire logic [14:0] regAddr,        // register byte address
  input  wire logic [7:0]  regWrData,      // register write data
  output logic      [7:0]  regRdData,      // register read data, one cycle after read
  output logic             secondTick,     // calibrated one-second pulse
  output logic             ftOut,          // test pin output level (always low)
  output logic             ftOe,           // test pin output enable, high drives low
  output logic             writeClockBit,  // write clock bit state
  output logic             sleepBit,       // sleep bit state
  output logic             tamperEnable    // tamper enable bit state
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] syncA_reg, syncA_next;
  logic [3:0] syncB_reg, syncB_next;
  logic       oscPrev_reg, oscPrev_next;
  logic       upPrev_reg, upPrev_next;
  logic       attPrev_reg, attPrev_next;

  logic oscS, upS, attS, supplyS, battLowS;
  logic oscEdge, upEdge, downEdge, attEdge;

  always_comb begin
    syncA_next   = {oscIn, powerUp, batteryAttach, mainSupplyOk};
    syncB_next   = syncA_reg;
    oscPrev_next = oscS;
    upPrev_next  = upS;
    attPrev_next = attS;
  end

  logic batA_reg, batB_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_reg   <= 4'h0;
      syncB_reg   <= 4'h0;
      oscPrev_reg <= 1'b0;
      upPrev_reg  <= 1'b0;
      attPrev_reg <= 1'b0;
      batA_reg    <= 1'b0;
      batB_reg    <= 1'b0;
    end else begin
      syncA_reg   <= syncA_next;
      syncB_reg   <= syncB_next;
      oscPrev_reg <= oscPrev_next;
      upPrev_reg  <= upPrev_next;
      attPrev_reg <= attPrev_next;
      batA_reg    <= batteryLowIn;
      batB_reg    <= batA_reg;
    end
  end

  assign oscS     = syncB_reg[3];
  assign upS      = syncB_reg[2];
  assign attS     = syncB_reg[1];
  assign supplyS  = syncB_reg[0];
  assign battLowS = batB_reg;
  assign oscEdge  = oscS & ~oscPrev_reg;
  assign upEdge   = upS & ~upPrev_reg;
  assign downEdge = ~upS & upPrev_reg;
  assign attEdge  = attS & ~attPrev_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg, control_next;
  logic       oscStop_reg, oscStop_next;
  logic       freqTestEnable_reg, freqTestEnable_next;
  logic       tamperEnable_reg, tamperEnable_next;
  logic [2:0] dayOfWeek_reg, dayOfWeek_next;
  logic       batteryLowFlag_reg, batteryLowFlag_next;
  logic [7:0] rdData_reg, rdData_next;

  always_comb begin
    control_next        = control_reg;
    oscStop_next        = oscStop_reg;
    freqTestEnable_next = freqTestEnable_reg;
    tamperEnable_next   = tamperEnable_reg;
    dayOfWeek_next      = dayOfWeek_reg;
    batteryLowFlag_next = batteryLowFlag_reg;
    rdData_next         = 8'h00;

    if (regWrite) begin
      if (regAddr == rtc_cal_pkg::ADDR_CONTROL) begin
        control_next = regWrData;
      end else if (regAddr == rtc_cal_pkg::ADDR_SECONDS) begin
        oscStop_next = regWrData[rtc_cal_pkg::SEC_STOP_BIT];
      end else if (regAddr == rtc_cal_pkg::ADDR_DAY) begin
        freqTestEnable_next = regWrData[rtc_cal_pkg::DAY_FT_BIT];
        tamperEnable_next   = regWrData[rtc_cal_pkg::DAY_TEB_BIT];
        dayOfWeek_next      = regWrData[rtc_cal_pkg::DAY_DOW_HI:rtc_cal_pkg::DAY_DOW_LO];
      end
    end

    // power events override a coincident host write; tamper, stop and sleep are kept
    if (downEdge || upEdge || attEdge) begin
      control_next[rtc_cal_pkg::CTRL_WC_BIT] = 1'b0;
      freqTestEnable_next                    = 1'b0;
    end

    // flag is only re-evaluated by a power-up test under main supply
    if (upEdge && supplyS) begin
      batteryLowFlag_next = battLowS;
    end

    if (regRead) begin
      if (regAddr == rtc_cal_pkg::ADDR_CONTROL) begin
        rdData_next = control_reg;
      end else if (regAddr == rtc_cal_pkg::ADDR_SECONDS) begin
        rdData_next[rtc_cal_pkg::SEC_STOP_BIT] = oscStop_reg;
      end else if (regAddr == rtc_cal_pkg::ADDR_DAY) begin
        rdData_next[rtc_cal_pkg::DAY_BL_BIT]  = batteryLowFlag_reg;
        rdData_next[rtc_cal_pkg::DAY_FT_BIT]  = freqTestEnable_reg;
        rdData_next[rtc_cal_pkg::DAY_TEB_BIT] = tamperEnable_reg;
        rdData_next[rtc_cal_pkg::DAY_TB_BIT]  = tamperFlagIn;
        rdData_next[rtc_cal_pkg::DAY_DOW_HI:rtc_cal_pkg::DAY_DOW_LO] = dayOfWeek_reg;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_reg        <= rtc_cal_pkg::CONTROL_RESET;
      oscStop_reg        <= 1'b0;
      freqTestEnable_reg <= 1'b0;
      tamperEnable_reg   <= 1'b0;
      dayOfWeek_reg      <= rtc_cal_pkg::DOW_RESET;
      batteryLowFlag_reg <= 1'b0;
      rdData_reg         <= 8'h00;
    end else begin
      control_reg        <= control_next;
      oscStop_reg        <= oscStop_next;
      freqTestEnable_reg <= freqTestEnable_next;
      tamperEnable_reg   <= tamperEnable_next;
      dayOfWeek_reg      <= dayOfWeek_next;
      batteryLowFlag_reg <= batteryLowFlag_next;
      rdData_reg         <= rdData_next;
    end
  end

  assign regRdData     = rdData_reg;
  assign writeClockBit = control_reg[rtc_cal_pkg::CTRL_WC_BIT];
  assign sleepBit      = control_reg[rtc_cal_pkg::CTRL_SLP_BIT];
  assign tamperEnable  = tamperEnable_reg;

  // ----------------------------------------------------------------
  // divider chain with calibration
  // ----------------------------------------------------------------
  // the stop bit freezes the whole chain; nothing is counted while it is set
  logic [rtc_cal_pkg::STAGE_W-1:0]     stage_reg, stage_next;
  logic [rtc_cal_pkg::SEC_STAGE_W-1:0] secStage_reg, secStage_next;
  logic [5:0] secInMin_reg, secInMin_next;
  logic [5:0] cycleMin_reg, cycleMin_next;
  logic [4:0] calMag_reg, calMag_next;
  logic       calSign_reg, calSign_next;
  logic       modSecond_reg, modSecond_next;
  logic       corrDone_reg, corrDone_next;
  logic       tick_reg, tick_next;
  logic [4:0] calField;
  logic [6:0] twiceMag;
  logic       eligible;
  logic       stageWrap;
  logic       secWrap;

  assign calField = control_reg[rtc_cal_pkg::CTRL_CAL_HI:rtc_cal_pkg::CTRL_CAL_LO];
  assign twiceMag = {1'b0, calField, 1'b0};

  always_comb begin
    stage_next     = stage_reg;
    secStage_next  = secStage_reg;
    secInMin_next  = secInMin_reg;
    cycleMin_next  = cycleMin_reg;
    calMag_next    = calMag_reg;
    calSign_next   = calSign_reg;
    modSecond_next = modSecond_reg;
    corrDone_next  = corrDone_reg;
    tick_next      = 1'b0;
    stageWrap      = 1'b0;
    secWrap        = 1'b0;
    eligible       = 1'b0;

    if (oscEdge && !oscStop_reg) begin
      stage_next = stage_reg + 8'h01;
      if (stage_reg == rtc_cal_pkg::STAGE_LAST) begin
        stageWrap = 1'b1;
        if (modSecond_reg && !corrDone_reg) begin
          corrDone_next = 1'b1;
          if (calSign_reg) begin
            // one extra 256-count pulse: second ends 256 counts early, clock runs fast
            if (secStage_reg >= rtc_cal_pkg::SEC_STAGE_SKIP) begin
              secWrap = 1'b1;
            end else begin
              secStage_next = secStage_reg + 7'h02;
            end
          end else begin
            // pulse blanked and stage restarted half way: 128 counts lost, clock runs slow
            stage_next = rtc_cal_pkg::NEG_RESTART;
          end
        end else if (secStage_reg == rtc_cal_pkg::SEC_STAGE_LAST) begin
          secWrap = 1'b1;
        end else begin
          secStage_next = secStage_reg + 7'h01;
        end
      end
    end

    if (secWrap) begin
      secStage_next  = '0;
      tick_next      = 1'b1;
      modSecond_next = 1'b0;
      if (secInMin_reg == rtc_cal_pkg::SEC_PER_MIN_END) begin
        secInMin_next = '0;
        cycleMin_next = cycleMin_reg + 6'h01;
        // the minute starting now: its first second is the one corrected
        eligible = ((cycleMin_next < rtc_cal_pkg::ELIGIBLE_MINUTES) &&
                    ({1'b0, cycleMin_next} < twiceMag));
        calMag_next    = calField;
        calSign_next   = control_reg[rtc_cal_pkg::CTRL_SIGN_BIT];
        modSecond_next = eligible && (calField != 5'h00);
        corrDone_next  = 1'b0;
      end else begin
        secInMin_next = secInMin_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_reg     <= '0;
      secStage_reg  <= '0;
      secInMin_reg  <= '0;
      cycleMin_reg  <= rtc_cal_pkg::CYCLE_MIN_END;
      calMag_reg    <= '0;
      calSign_reg   <= 1'b0;
      modSecond_reg <= 1'b0;
      corrDone_reg  <= 1'b0;
      tick_reg      <= 1'b0;
    end else begin
      stage_reg     <= stage_next;
      secStage_reg  <= secStage_next;
      secInMin_reg  <= secInMin_next;
      cycleMin_reg  <= cycleMin_next;
      calMag_reg    <= calMag_next;
      calSign_reg   <= calSign_next;
      modSecond_reg <= modSecond_next;
      corrDone_reg  <= corrDone_next;
      tick_reg      <= tick_next;
    end
  end

  assign secondTick = tick_reg;

  // ----------------------------------------------------------------
  // 512 Hz test output
  // ----------------------------------------------------------------
  // own raw counter, so calibration never moves the test frequency
  logic [rtc_cal_pkg::FT_TAP:0] ftCnt_reg, ftCnt_next;
  logic                         ftOe_reg, ftOe_next;

  always_comb begin
    ftCnt_next = ftCnt_reg;
    if (oscEdge && !oscStop_reg) begin
      ftCnt_next = ftCnt_reg + 1'b1;
    end
    // open drain: low phase drives, high phase releases to the pull-up
    ftOe_next = freqTestEnable_reg && !oscStop_reg &&
                !ftCnt_reg[rtc_cal_pkg::FT_TAP];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ftCnt_reg <= '0;
      ftOe_reg  <= 1'b0;
    end else begin
      ftCnt_reg <= ftCnt_next;
      ftOe_reg  <= ftOe_next;
    end
  end

  assign ftOut = 1'b0;
  assign ftOe  = ftOe_reg;

endmodule : rtc_calibration_and_flags

// ---- rtc_cal_pkg.sv ----
// Behaviour
// - correct counts at divide-by-256 stage only
// - magnitude is control bits four to zero
// - control bit five is calibration sign
// - positive runs faster, negative runs slower
// - 64-minute cycle, first 62 minutes eligible
// - add 256 or remove 128 counts
// - magnitude N modifies first 2N minutes
// - test pin toggles 512 Hz when enabled
// - test output taken before calibration point
// - test pin is open drain
// - power-down clears test enable bit
// - power-up battery test sets low flag
// - low flag holds until next power-up test
// - battery tested only with main supply
// - attach or first power-up clears write, test
// - power-cycle clears write, test; others kept
// - calibration lives in control at 0x7ff8
// - stop bit is seconds register top bit
// - test enable is day register bit six
package rtc_cal_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_CONTROL = 15'h7ff8;
  localparam logic [14:0] ADDR_SECONDS = 15'h7ff9;
  localparam logic [14:0] ADDR_DAY     = 15'h7ffc;

  // control register fields
  localparam int CTRL_WC_BIT   = 7;
  localparam int CTRL_SLP_BIT  = 6;
  localparam int CTRL_SIGN_BIT = 5;
  localparam int CTRL_CAL_HI   = 4;
  localparam int CTRL_CAL_LO   = 0;

  // seconds register fields
  localparam int SEC_STOP_BIT = 7;

  // day register fields
  localparam int DAY_BL_BIT  = 7;
  localparam int DAY_FT_BIT  = 6;
  localparam int DAY_TEB_BIT = 5;
  localparam int DAY_TB_BIT  = 4;
  localparam int DAY_DOW_HI  = 2;
  localparam int DAY_DOW_LO  = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] DOW_RESET     = 3'h0;

  // ----------------------------------------------------------------
  // divider chain and calibration cycle
  // ----------------------------------------------------------------
  localparam int          STAGE_W         = 8;          // divide-by-256 stage
  localparam logic [7:0]  STAGE_LAST      = 8'hff;
  localparam logic [7:0]  NEG_RESTART     = 8'h80;      // 128 counts blanked
  localparam int          SEC_STAGE_W     = 7;          // 128 stage pulses a second
  localparam logic [6:0]  SEC_STAGE_LAST  = 7'h7f;
  localparam logic [6:0]  SEC_STAGE_SKIP  = 7'h7e;      // one 256-count pulse inserted
  localparam logic [5:0]  SEC_PER_MIN_END = 6'h3b;      // 59
  localparam logic [5:0]  CYCLE_MIN_END   = 6'h3f;      // 63
  localparam logic [5:0]  ELIGIBLE_MINUTES = 6'h3e;     // 62
  localparam int          FT_TAP          = 5;          // 32768 / 64 = 512 Hz

endpackage : rtc_cal_pkg

// ---- rtc_cal_checker.sv ----
module rtc_cal_checker (
  input wire logic        sys_clk,        // clock
  input wire logic        rst,            // reset
  input wire logic        powerUp,        // supply level
  input wire logic        regWrite,       // write strobe
  input wire logic        regRead,        // read strobe
  input wire logic [14:0] regAddr,        // address
  input wire logic [7:0]  regWrData,      // write data
  input wire logic [7:0]  regRdData,      // read data
  input wire logic        secondTick,     // one-second pulse
  input wire logic        ftOut,          // test pin data
  input wire logic        ftOe,           // test pin enable
  input wire logic        writeClockBit,  // control bit 7
  input wire logic        sleepBit,       // control bit 6
  input wire logic        tamperEnable    // day bit 5
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ctlWr;
  logic mapped;
  assign ctlWr  = regWrite && regAddr == rtc_cal_pkg::ADDR_CONTROL;
  assign mapped = regAddr == rtc_cal_pkg::ADDR_CONTROL || regAddr == rtc_cal_pkg::ADDR_SECONDS
                  || regAddr == rtc_cal_pkg::ADDR_DAY;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_pin_open_drain: assert property (ftOut == 1'b0)
    else $error("test pin data not low");
  chk_tick_single: assert property (secondTick |=> !secondTick)
    else $error("second pulse longer than one cycle");
  chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not cleared");
  chk_read_unmapped: assert property (regRead && !mapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_control_bits: assert property (ctlWr |=> writeClockBit == $past(regWrData[7])
    && sleepBit == $past(regWrData[6])) else $error("control bits not stored");
  chk_tamper_enable: assert property (regWrite && regAddr == rtc_cal_pkg::ADDR_DAY
    |=> tamperEnable == $past(regWrData[5])) else $error("tamper enable not stored");
  chk_cal_readback: assert property (ctlWr ##1 !regWrite ##1 (regRead && !regWrite
    && regAddr == rtc_cal_pkg::ADDR_CONTROL) |=> regRdData == $past(regWrData, 3))
    else $error("control read back wrong");
  // generous delay: power edges pass a synchroniser before they clear the bit
  chk_powerdown_ft: assert property ($fell(powerUp) |-> ##8 !ftOe [*8])
    else $error("test pin active after power-down");
  chk_stop_ft: assert property (regWrite && regAddr == rtc_cal_pkg::ADDR_SECONDS
    && regWrData[7] |=> ##4 !ftOe [*8]) else $error("test pin active while stopped");
endmodule : rtc_cal_checker

bind rtc_calibration_and_flags rtc_cal_checker rtc_cal_checker_i (
  .sys_clk, .rst, .powerUp, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
  .secondTick, .ftOut, .ftOe, .writeClockBit, .sleepBit, .tamperEnable);

// ---- osc_and_pullup.sv ----
module osc_and_pullup #(
  parameter int HALF_NS = 40  // oscillator half period, far faster than a crystal
) (
  output logic      oscIn,  // oscillator square wave
  input  wire logic ftOut,  // test pin data
  input  wire logic ftOe,   // test pin enable
  output wire logic ftPin   // resolved pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  // free running: a crystal never pauses between frames
  initial begin
    oscIn = 1'b0;
    forever #(HALF_NS) oscIn = ~oscIn;
  end
  // released pin rises through the external pull-up
  assign ftPin = ftOe ? ftOut : 1'b1;
endmodule : osc_and_pullup

// ---- rtc_calibration_and_flags_tb.sv ----
module rtc_calibration_and_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [14:0] CTL = rtc_cal_pkg::ADDR_CONTROL;
  localparam logic [14:0] SEC = rtc_cal_pkg::ADDR_SECONDS;
  localparam logic [14:0] DAY = rtc_cal_pkg::ADDR_DAY;
  // fast oscillator: at crystal rate one second would not fit the run budget
  localparam int          OSC_HALF  = 10;
  localparam int          CYC_COUNT = 2 * OSC_HALF / 10;
  localparam logic [15:0] FT_CYC    = 16'((2 ** (rtc_cal_pkg::FT_TAP + 1)) * CYC_COUNT);
  localparam int          TICK_CYC  = (2 ** (rtc_cal_pkg::STAGE_W + rtc_cal_pkg::SEC_STAGE_W))
                                      * CYC_COUNT;
  localparam int          CEILING   = TICK_CYC + 12000;
  logic        sys_clk, rst, oscIn, powerUp, batteryAttach, mainSupplyOk;
  logic        batteryLowIn, tamperFlagIn, regWrite, regRead, secondTick;
  logic        ftOut, ftOe, ftPin, writeClockBit, sleepBit, tamperEnable;
  logic [14:0] regAddr;
  logic [7:0]  regWrData, regRdData;
  logic [15:0] n;
  logic [7:0]  calv [5] = '{8'h1f, 8'h3f, 8'h20, 8'h01, 8'hc6};
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          waitCycles = 0;

  rtc_calibration_and_flags rtc_calibration_and_flags_i (
    .sys_clk, .rst, .oscIn, .powerUp, .batteryAttach, .mainSupplyOk, .batteryLowIn,
    .tamperFlagIn, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .secondTick,
    .ftOut, .ftOe, .writeClockBit, .sleepBit, .tamperEnable);
  osc_and_pullup #(.HALF_NS(OSC_HALF)) osc_and_pullup_i (.oscIn, .ftOut, .ftOe, .ftPin);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite  <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [14:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 check({8'h00, regRdData}, {8'h00, e});
  endtask : rdc
  // power inputs are asynchronous: give the synchroniser time before any access
  task automatic settle;
    repeat (20) @(posedge sys_clk);
  endtask : settle
  // cycles between two rising edges of the resolved pin
  task automatic period(output logic [15:0] p);
    int k;
    k = 0;
    p = 0;
    for (int i = 0; i < 4; i++) begin
      while (ftPin !== i[0] && k < 4000) begin
        @(posedge sys_clk);
        k++;
      end
      if (i == 1) p = k[15:0];
    end
    p = k[15:0] - p;
  endtask : period
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == CEILING) begin
      miscompares++;
      close_out;
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    powerUp = 1'b1;
    batteryAttach = 1'b1;
    mainSupplyOk = 1'b1;
    batteryLowIn = 1'b0;
    tamperFlagIn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 15'h0000;
    regWrData = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(CTL, 8'h00);
    rdc(DAY, 8'h00);
    rdc(SEC, 8'h00);
    done("reset");
    foreach (calv[i]) begin
      wr(CTL, calv[i]);
      rdc(CTL, calv[i]);
    end
    wr(15'h7ff0, 8'hff);
    rdc(15'h7ff0, 8'h00);
    rdc(CTL, 8'hc6);
    wr(SEC, 8'h7f);
    rdc(SEC, 8'h00);
    @(posedge sys_clk) tamperFlagIn <= 1'b1;
    wr(DAY, 8'hff);
    rdc(DAY, 8'h77);
    @(posedge sys_clk) tamperFlagIn <= 1'b0;
    rdc(DAY, 8'h67);
    done("registers");
    period(n);
    check(n, FT_CYC);
    wr(CTL, 8'h3f);
    period(n);
    check(n, FT_CYC);
    wr(SEC, 8'h80);
    rdc(SEC, 8'h80);
    n = 0;
    repeat (600) begin
      @(posedge sys_clk);
      if (ftPin !== 1'b1) n++;
    end
    check(n, 16'd0);
    wr(SEC, 8'h00);
    period(n);
    check(n, FT_CYC);
    done("test pin");
    wr(CTL, 8'hc6);
    @(posedge sys_clk) powerUp <= 1'b0;
    settle;
    rdc(CTL, 8'h46);
    rdc(DAY, 8'h27);
    wr(DAY, 8'h67);
    wr(CTL, 8'hc6);
    @(posedge sys_clk) batteryLowIn <= 1'b1;
    @(posedge sys_clk) powerUp <= 1'b1;
    settle;
    rdc(CTL, 8'h46);
    rdc(DAY, 8'ha7);
    done("power cycle");
    @(posedge sys_clk) powerUp <= 1'b0;
    settle;
    mainSupplyOk <= 1'b0;
    batteryLowIn <= 1'b0;
    @(posedge sys_clk) powerUp <= 1'b1;
    settle;
    rdc(DAY, 8'ha7);
    @(posedge sys_clk) powerUp <= 1'b0;
    settle;
    mainSupplyOk <= 1'b1;
    @(posedge sys_clk) powerUp <= 1'b1;
    settle;
    rdc(DAY, 8'h27);
    done("battery");
    wr(CTL, 8'hc6);
    wr(DAY, 8'h67);
    @(posedge sys_clk) batteryAttach <= 1'b0;
    settle;
    batteryAttach <= 1'b1;
    settle;
    rdc(CTL, 8'h46);
    rdc(DAY, 8'h27);
    done("attach");
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    waitCycles = 0;
    while (secondTick !== 1'b1 && waitCycles < TICK_CYC + 100) begin
      @(posedge sys_clk);
      #1;
      waitCycles++;
    end
    // first second after reset falls in cycle minute 63, never corrected
    check(16'(waitCycles >= TICK_CYC && waitCycles <= TICK_CYC + 4), 16'h0001);
    @(posedge sys_clk);
    #1 check({15'h0000, secondTick}, 16'h0000);
    rdc(CTL, 8'h00);
    rdc(DAY, 8'h00);
    done("second tick");
    close_out;
  end
endmodule : rtc_calibration_and_flags_tb
